/* logic/acrs_pkg.sv */
// constants for the audio clock ratio select block
package acrs_pkg;
   // register word indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL = 8'h31;
   localparam logic [7:0] IDX_DIV_LO = 8'h3D;
   localparam logic [7:0] IDX_DIV_HI = 8'h3E;
   localparam logic [7:0] IDX_OUT1 = 8'h3F;
   localparam logic [7:0] IDX_OUT2 = 8'h40;
   localparam logic [7:0] IDX_OUT3 = 8'h41;
   localparam logic [7:0] IDX_RESERVED_GAP = 8'h42;
   localparam logic [7:0] IDX_STATUS = 8'h50;
   // field layout
   localparam int CTRL_HI_RATE_BIT = 5;
   localparam int STAT_MANUAL_BIT = 0;
   localparam int STAT_CONFLICT_BIT = 1;
   localparam int RATE_W = 3;
   localparam int MULT_W = 10;
   localparam int HALF_W = 16;
   localparam int NUM_OUT = 3;
   // reset values
   localparam logic [RATE_W-1:0] RATE_RST = 3'h0;
   localparam logic [31:0] DIV_RST = 32'h0000_0000;
   localparam logic HI_RATE_RST = 1'b0;
   // selector code to fs multiple; zero marks the z-bit (output off)
   localparam logic [MULT_W-1:0] MULT_TABLE [8] = '{
      10'h200, 10'h180, 10'h100, 10'h0C0, 10'h080, 10'h040, 10'h001, 10'h000};
   // codes whose multiple needs the high-rate control bit
   localparam logic [7:0] NEEDS_HI_RATE = 8'h0A;
endpackage : acrs_pkg

/* logic/acrs_audio_clock_ratio_select.sv */
// register file and rate decode for the audio clock ratio section
//////////////////////////////////////////////////////////////////////
// Function
// R1: 32-bit software value is the audio genlock divide denominator.
// R2: divisor split: low index holds bits 15-0, next index bits 31-16.
// R3: a software write switches the divisor to manual audio-to-video lock.
// R4: until written, divisor follows the value of the selected video standard.
// R5: 3-bit selector sets output 1 multiple of fs; resets to zero.
// R6: independent 3-bit selector for output 2, same choices, resets zero.
// R7: independent 3-bit selector for output 3, same choices, resets zero.
// R8: software sets control bit 5 when choosing 384fs or 192fs.
// R9: software writes zeros to reserved selector bits 15-3.
// R10: selector code to multiple follows a fixed mapping table.
module acrs_audio_clock_ratio_select #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // apb slave
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // divisor of the selected video standard
   input wire logic [31:0] video_std_divisor,
   // genlock loop configuration
   output logic [31:0] audio_ref_divisor,
   output logic manual_lock,
   output logic high_rate_enable,
   output logic rate_conflict,
   // audio clock output settings
   output logic [acrs_pkg::RATE_W-1:0] audio_clock_out_1_code,
   output logic [acrs_pkg::RATE_W-1:0] audio_clock_out_2_code,
   output logic [acrs_pkg::RATE_W-1:0] audio_clock_out_3_code,
   output logic [acrs_pkg::MULT_W-1:0] audio_clock_out_1_mult,
   output logic [acrs_pkg::MULT_W-1:0] audio_clock_out_2_mult,
   output logic [acrs_pkg::MULT_W-1:0] audio_clock_out_3_mult,
   output logic [acrs_pkg::NUM_OUT-1:0] audio_clock_out_drive
);
   import acrs_pkg::*;

   typedef struct packed {
      logic [31:0] div;
      logic manual;
      logic hi_rate;
      logic [NUM_OUT-1:0][RATE_W-1:0] rate;
      logic [NUM_OUT-1:0][MULT_W-1:0] mult;
      logic [NUM_OUT-1:0] drive;
      logic conflict;
      logic [31:0] rdata;
      logic err;
   } acrs_state_t;

   acrs_state_t state;
   acrs_state_t next_state;

   //////////////////////////////////////////////////////////////////////
   // reset image of the state

   // every output starts at code zero, which is a driven clock
   // divisor starts at zero and picks up the video standard next edge
   localparam acrs_state_t STATE_RST = '{
      div: DIV_RST,
      manual: 1'b0,
      hi_rate: HI_RATE_RST,
      rate: {NUM_OUT{RATE_RST}},
      mult: {NUM_OUT{MULT_TABLE[RATE_RST]}},
      drive: {NUM_OUT{MULT_TABLE[RATE_RST] != '0}},
      conflict: 1'b0,
      rdata: 32'h0000_0000,
      err: 1'b0
   };

   //////////////////////////////////////////////////////////////////////
   // address decode

   // word index and alignment
   logic [7:0] idx;
   logic aligned;
   logic mapped;
   // transfer phases
   logic setup;
   logic access;
   logic wr;
   // per-register write enables
   logic ctrl_wr;
   logic div_lo_wr;
   logic div_hi_wr;

   // index must survive the narrowing to eight bits
   assign idx = 8'(paddr[ADDR_W-1:2]);
   assign aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
   assign mapped = aligned && (idx == IDX_CTRL || idx == IDX_DIV_LO || idx == IDX_DIV_HI
      || idx == IDX_OUT1 || idx == IDX_OUT2 || idx == IDX_OUT3 || idx == IDX_RESERVED_GAP
      || idx == IDX_STATUS);

   //////////////////////////////////////////////////////////////////////
   // transfer phases

   assign setup = psel && !penable;
   assign access = psel && penable;
   assign wr = access && pwrite && mapped;

   // R8 control bit write
   assign ctrl_wr = wr && (idx == IDX_CTRL) && pstrb[0];
   // R2 per-half divisor writes
   assign div_lo_wr = wr && (idx == IDX_DIV_LO);
   assign div_hi_wr = wr && (idx == IDX_DIV_HI);

   //////////////////////////////////////////////////////////////////////
   // per-output selectors and decode

   logic [NUM_OUT-1:0] sel_wr;
   logic [NUM_OUT-1:0][RATE_W-1:0] sel_rate;
   logic [NUM_OUT-1:0][MULT_W-1:0] dec_mult;
   logic [NUM_OUT-1:0] dec_drive;
   logic [NUM_OUT-1:0] need_hi;

   generate
      for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
         // R5 R6 R7 selector write
         assign sel_wr[i] = wr && pstrb[0] && (idx == IDX_OUT1 + 8'(i));
         // reserved bits 15-3 are dropped here
         assign sel_rate[i] = sel_wr[i] ? pwdata[RATE_W-1:0] : state.rate[i];
         // R10 code to multiple
         assign dec_mult[i] = MULT_TABLE[sel_rate[i]];
         // zero multiple means the output floats
         assign dec_drive[i] = (dec_mult[i] != '0);
         // R8 high-rate dependency
         assign need_hi[i] = NEEDS_HI_RATE[sel_rate[i]];
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////
   // divisor source

   logic [31:0] auto_div;

   // R4 follow video standard
   // once software writes either half only further software writes change the value until reset
   always_comb begin
      if (state.manual) begin
         auto_div = state.div;
      end else begin
         auto_div = video_std_divisor;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // read mux

   // 31h control: bit 5 high-rate enable
   // 3dh, 3eh: divisor low and high halves
   // 3fh, 40h, 41h: output selectors, bits 2-0
   // 42h: reserved, reads zero, no error
   // 50h: status, bit 0 manual lock, bit 1 conflict
   // anything else answers with an error and zero

   logic [31:0] read_word;

   always_comb begin
      read_word = 32'h0000_0000;
      case (idx)
         IDX_CTRL: begin
            read_word[CTRL_HI_RATE_BIT] = state.hi_rate;
         end
         // R1 divisor readback
         IDX_DIV_LO: begin
            read_word[HALF_W-1:0] = state.div[HALF_W-1:0];
         end
         IDX_DIV_HI: begin
            read_word[HALF_W-1:0] = state.div[31:HALF_W];
         end
         // R9 reserved bits read zero
         IDX_OUT1: begin
            read_word[RATE_W-1:0] = state.rate[0];
         end
         IDX_OUT2: begin
            read_word[RATE_W-1:0] = state.rate[1];
         end
         IDX_OUT3: begin
            read_word[RATE_W-1:0] = state.rate[2];
         end
         // reserved gap reads zero
         IDX_RESERVED_GAP: begin
            read_word = 32'h0000_0000;
         end
         // status bits
         IDX_STATUS: begin
            read_word[STAT_MANUAL_BIT] = state.manual;
            read_word[STAT_CONFLICT_BIT] = state.conflict;
         end
         default: begin
            read_word = 32'h0000_0000;
         end
      endcase
      // misaligned aliases must not leak
      if (!mapped) begin
         read_word = 32'h0000_0000;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_state = state;
      next_state.div = auto_div;
      // R8 control bit
      if (ctrl_wr) begin
         next_state.hi_rate = pwdata[CTRL_HI_RATE_BIT];
      end
      // R2 low half
      if (div_lo_wr) begin
         if (pstrb[0]) begin
            next_state.div[7:0] = pwdata[7:0];
         end
         if (pstrb[1]) begin
            next_state.div[15:8] = pwdata[15:8];
         end
         // R3 manual lock
         next_state.manual = 1'b1;
      end
      // R2 high half
      if (div_hi_wr) begin
         if (pstrb[0]) begin
            next_state.div[23:16] = pwdata[7:0];
         end
         if (pstrb[1]) begin
            next_state.div[31:24] = pwdata[15:8];
         end
         // R3 manual lock
         next_state.manual = 1'b1;
      end
      // selectors carry their own write logic
      next_state.rate = sel_rate;
      // R10 registered decode
      next_state.mult = dec_mult;
      next_state.drive = dec_drive;
      // R8 flag missing high-rate bit
      next_state.conflict = (|need_hi) && !next_state.hi_rate;
      // read data captured in setup phase
      if (setup) begin
         next_state.err = !mapped;
         next_state.rdata = read_word;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge core_clk) begin
      // R5 R6 R7 zero reset
      if (srst) begin
         state <= STATE_RST;
      end else begin
         state <= next_state;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // apb response

   // no wait states: every access ends at its first access edge
   assign pready = 1'b1;
   // read word was captured at the setup edge
   assign prdata = state.rdata;
   // error shows only during the access phase
   assign pslverr = access && state.err;

   //////////////////////////////////////////////////////////////////////
   // genlock loop configuration

   // R1 divisor to loop
   assign audio_ref_divisor = state.div;
   assign manual_lock = state.manual;
   assign high_rate_enable = state.hi_rate;
   // flag only; the high-rate bit is never forced
   assign rate_conflict = state.conflict;

   //////////////////////////////////////////////////////////////////////
   // audio clock output settings

   assign audio_clock_out_1_code = state.rate[0];
   assign audio_clock_out_2_code = state.rate[1];
   assign audio_clock_out_3_code = state.rate[2];

   assign audio_clock_out_1_mult = state.mult[0];
   assign audio_clock_out_2_mult = state.mult[1];
   assign audio_clock_out_3_mult = state.mult[2];

   // one enable per output, low for z-bit
   assign audio_clock_out_drive = state.drive;

endmodule : acrs_audio_clock_ratio_select

/* tb/acrs_monitor.sv */
// assertion checker for the audio clock ratio select block
module acrs_monitor #(
   parameter int ADDR_W = 12
) (
   // apb side
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pslverr,
   // configuration outputs
   input wire logic [31:0] video_std_divisor,
   input wire logic [31:0] audio_ref_divisor,
   input wire logic manual_lock,
   input wire logic high_rate_enable,
   input wire logic rate_conflict,
   input wire logic [acrs_pkg::RATE_W-1:0] audio_clock_out_1_code,
   input wire logic [acrs_pkg::RATE_W-1:0] audio_clock_out_2_code,
   input wire logic [acrs_pkg::RATE_W-1:0] audio_clock_out_3_code,
   input wire logic [acrs_pkg::MULT_W-1:0] audio_clock_out_1_mult,
   input wire logic [acrs_pkg::NUM_OUT-1:0] audio_clock_out_drive
);
   timeunit 1ns;
   timeprecision 1ps;
   import acrs_pkg::*;
   logic wr;
   logic div_wr;
   assign wr = psel && penable && pwrite;
   assign div_wr = wr && (paddr == 12'h0F4 || paddr == 12'h0F8);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (srst);
   //////////////////////////////////////////////////////////////////////
   chk_div_low: assert property (wr && paddr == 12'h0F4 && pstrb[1:0] == 2'h3
      |=> audio_ref_divisor[15:0] == $past(pwdata[15:0])) else $error("divisor low half");
   chk_div_high: assert property (wr && paddr == 12'h0F8 && pstrb[1:0] == 2'h3
      |=> audio_ref_divisor[31:16] == $past(pwdata[15:0])) else $error("divisor high half");
   chk_manual_set: assert property (div_wr |=> manual_lock[*8])
      else $error("manual lock not held");
   chk_manual_frozen: assert property (manual_lock && !div_wr |=> $stable(audio_ref_divisor))
      else $error("manual divisor moved");
   chk_auto_track: assert property (!manual_lock && !div_wr
      |=> audio_ref_divisor == $past(video_std_divisor)) else $error("divisor not tracking");
   chk_sel1_write: assert property (wr && paddr == 12'h0FC && pstrb[0]
      |=> audio_clock_out_1_code == $past(pwdata[2:0])) else $error("selector 1 write");
   chk_sel2_write: assert property (wr && paddr == 12'h100 && pstrb[0]
      |=> audio_clock_out_2_code == $past(pwdata[2:0])) else $error("selector 2 write");
   chk_sel3_write: assert property (wr && paddr == 12'h104 && pstrb[0]
      |=> audio_clock_out_3_code == $past(pwdata[2:0])) else $error("selector 3 write");
   chk_sel_reset: assert property ($fell(srst) |-> audio_clock_out_1_code == 3'h0
      && audio_clock_out_2_code == 3'h0 && audio_clock_out_3_code == 3'h0) else $error("sel reset");
   chk_mult_decode: assert property (audio_clock_out_1_mult == MULT_TABLE[audio_clock_out_1_code]
      && audio_clock_out_drive[0] == (audio_clock_out_1_code != 3'h7)) else $error("decode");
   chk_conflict_flag: assert property (rate_conflict == (!high_rate_enable
      && (NEEDS_HI_RATE[audio_clock_out_1_code] || NEEDS_HI_RATE[audio_clock_out_2_code]
      || NEEDS_HI_RATE[audio_clock_out_3_code]))) else $error("conflict flag");
   chk_unmapped_err: assert property (psel && penable && paddr == 12'h200 |-> pslverr)
      else $error("no error on unmapped");
endmodule : acrs_monitor
bind acrs_audio_clock_ratio_select acrs_monitor #(.ADDR_W(ADDR_W)) mon (
   .core_clk(core_clk),
   .srst(srst),
   .paddr(paddr),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .pwdata(pwdata),
   .pstrb(pstrb),
   .pslverr(pslverr),
   .video_std_divisor(video_std_divisor),
   .audio_ref_divisor(audio_ref_divisor),
   .manual_lock(manual_lock),
   .high_rate_enable(high_rate_enable),
   .rate_conflict(rate_conflict),
   .audio_clock_out_1_code(audio_clock_out_1_code),
   .audio_clock_out_2_code(audio_clock_out_2_code),
   .audio_clock_out_3_code(audio_clock_out_3_code),
   .audio_clock_out_1_mult(audio_clock_out_1_mult),
   .audio_clock_out_drive(audio_clock_out_drive)
);

/* tb/acrs_audio_sink.sv */
// model of the converters fed by the audio clock outputs
module acrs_audio_sink (
   // clock presence at the converters
   input wire logic [2:0] audio_clock_out_drive,
   output logic [1:0] sink_live_count
);
   timeunit 1ns;
   timeprecision 1ps;
   assign sink_live_count = 2'(audio_clock_out_drive[0]) + 2'(audio_clock_out_drive[1])
      + 2'(audio_clock_out_drive[2]);
endmodule : acrs_audio_sink

/* tb/audio_clock_ratio_select_tb.sv */
// testbench for the audio clock ratio select block
module audio_clock_ratio_select_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 0;
   logic srst = 1;
   logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
   logic manual_lock, high_rate_enable, rate_conflict;
   logic [11:0] paddr = 0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] pwdata = 0, prdata, rd, audio_ref_divisor;
   logic [31:0] video_std_divisor = 32'h1234_5678;
   logic [2:0] audio_clock_out_1_code, audio_clock_out_2_code, audio_clock_out_3_code;
   logic [9:0] audio_clock_out_1_mult, audio_clock_out_2_mult, audio_clock_out_3_mult;
   logic [2:0] audio_clock_out_drive;
   logic [1:0] sink_live_count;
   logic [9:0] mt [8] = '{10'h200, 10'h180, 10'h100, 10'h0C0, 10'h080, 10'h040, 10'h001, 10'h000};
   wire [29:0] mo = {audio_clock_out_3_mult, audio_clock_out_2_mult, audio_clock_out_1_mult};
   wire [8:0] co = {audio_clock_out_3_code, audio_clock_out_2_code, audio_clock_out_1_code};
   int fail_count = 0, comparisons = 0, cyc = 0;
   acrs_audio_clock_ratio_select dut (
      .core_clk(core_clk),
      .srst(srst),
      .paddr(paddr),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .video_std_divisor(video_std_divisor),
      .audio_ref_divisor(audio_ref_divisor),
      .manual_lock(manual_lock),
      .high_rate_enable(high_rate_enable),
      .rate_conflict(rate_conflict),
      .audio_clock_out_1_code(audio_clock_out_1_code),
      .audio_clock_out_2_code(audio_clock_out_2_code),
      .audio_clock_out_3_code(audio_clock_out_3_code),
      .audio_clock_out_1_mult(audio_clock_out_1_mult),
      .audio_clock_out_2_mult(audio_clock_out_2_mult),
      .audio_clock_out_3_mult(audio_clock_out_3_mult),
      .audio_clock_out_drive(audio_clock_out_drive)
   );
   acrs_audio_sink sink (
      .audio_clock_out_drive(audio_clock_out_drive),
      .sink_live_count(sink_live_count)
   );
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         fail_count++;
         end_sim();
      end
   end
   //////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim
   task automatic ck(input string n, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : ck
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb
   //////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
      repeat (2) @(posedge core_clk);
      ck("auto divisor", 32'h1234_5678, audio_ref_divisor);
      for (int i = 0; i < 3; i++) begin
         apb(0, 12'h0FC + 12'(4 * i), 0);
         ck("selector reset", 0, rd);
         for (int c = 0; c < 8; c++) begin
            apb(1, 12'h0FC + 12'(4 * i), 32'(c));
            apb(0, 12'h0FC + 12'(4 * i), 0);
            ck("selector", 32'(c), rd);
            ck("code", 32'(c), 32'(co[3 * i +: 3]));
            ck("multiple", 32'(mt[c]), 32'(mo[10 * i +: 10]));
            ck("drive", 32'(c != 7), 32'(audio_clock_out_drive[i]));
         end
      end
      ck("live clocks", 0, 32'(sink_live_count));
      apb(1, 12'h100, 1);
      ck("conflict", 1, 32'(rate_conflict));
      ck("live clocks", 1, 32'(sink_live_count));
      apb(1, 12'h0C4, 32'h0000_0020);
      ck("high rate", 1, 32'(high_rate_enable));
      ck("conflict", 0, 32'(rate_conflict));
      apb(1, 12'h0C4, 0);
      ck("conflict", 1, 32'(rate_conflict));
      ck("manual", 0, 32'(manual_lock));
      apb(1, 12'h0F4, 32'h0000_ABCD);
      ck("manual", 1, 32'(manual_lock));
      ck("divisor low", 32'h0000_ABCD, 32'(audio_ref_divisor[15:0]));
      @(posedge core_clk);
      video_std_divisor <= 32'h0F0F_0F0F;
      apb(1, 12'h0F8, 32'h0000_1357);
      ck("divisor", 32'h1357_ABCD, audio_ref_divisor);
      apb(0, 12'h0F8, 0);
      ck("divisor high read", 32'h0000_1357, rd);
      apb(0, 12'h108, 0);
      ck("reserved read", 0, rd);
      ck("reserved error", 0, 32'(er));
      apb(0, 12'h200, 0);
      ck("unmapped error", 1, 32'(er));
      apb(0, 12'h140, 0);
      ck("status", 32'h0000_0003, rd);
      end_sim();
   end
endmodule : audio_clock_ratio_select_tb
